// ### design/edh_pid_cfg.svh
`ifndef EDH_PID_CFG_SVH
`define EDH_PID_CFG_SVH

// Register offsets on the host register port
`define OFS_EDH_FLAGS_OUTGOING   8'h03
`define OFS_FORMAT_STATUS        8'h04
`define OFS_PAYLOAD_ID_LOW       8'h0F
`define OFS_PAYLOAD_ID_HIGH      8'h10

// Field positions in the format status register
`define BIT_FLAG_REFRESH_ENABLE  11
`define BIT_PICTURE_CRC_VALID    10
`define BIT_FIELD_CRC_VALID      9
`define BIT_ERROR_PACKET_PRESENT 8
`define BIT_PAYLOAD_ID_VERSION   7
`define BIT_RASTER_INPUT_LOCK        4
`define FMT_CODE_MSB             3

// Reset values
`define RST_EDH_FLAGS            15'h0000
`define RST_PAYLOAD_WORD         8'h00
`define RST_FORMAT_CODE          4'h0

// Unknown status flags of the three areas (bits 14, 9, 4)
`define UES_MASK                 15'h4210

// Payload identifier packet shape
`define PID_USER_WORDS           4
`define PID_DATA_COUNT           8'h04
// Version bit position inside the first user word
`define PID_VERSION_BIT          7

`endif

// ### design/edh_pid_pkg.sv
package edh_pid_pkg;

    // Payload identifier packet parser states
    typedef enum logic [2:0] {
        PID_IDLE,
        PID_SDID,
        PID_COUNT,
        PID_USER,
        PID_CSUM
    } pid_state_t;

    // One captured user word
    typedef logic [7:0] pid_word_t;

endpackage

// ### design/edh_status_payload_id_regs.sv
`timescale 1ns/100ps
`include "edh_pid_cfg.svh"
// Notes on behaviour
// - Read-only 15 outgoing flags, three areas, reset zero
// - Writable refresh enable recomputes flags per RP165
// - Picture and field CRC valid bits readable
// - Packet present bit set when packets found
// - Version bit follows captured payload packet version
// - Raster input_lock bit shows flywheel synchronisation
// - Four-bit format code shown, reset zero
// - Recognise four-word payload identifier packet
// - Store four user words as 8-bit fields
// - Capture only when checksum matches local sum
// - Ignore packets arriving on wrong line
// - Clear captures on reset, lock loss, bypass
// - Words 1,2 at 0Fh; words 3,4 at 10h
// - Present drops at vblank end without packet
// - No packets forces unknown status flags high
// - CRC valid bits cleared while present low
// - Flags held; set to the unknown status flags at vblank end if none

module edh_status_payload_id_regs #(
    parameter int         ADDR_W  = 8,
    parameter logic [7:0] PID_DID = 8'h41,
    parameter logic [7:0] PID_SDID = 8'h01
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST,
    input  wire logic [ADDR_W-1:0] I_REG_ADDR,
    input  wire logic              I_REG_WR,
    input  wire logic              I_REG_RD,
    input  wire logic [15:0]       I_REG_WDATA,
    input  wire logic              I_INPUT_LOCK,
    input  wire logic              I_PROCESSING_BYPASS_N,
    input  wire logic              I_VBLANK,
    input  wire logic              I_EDH_PKT_VALID,
    input  wire logic [14:0]       I_EDH_FLAGS_IN,
    input  wire logic              I_EDH_PICTURE_CRC_VALID,
    input  wire logic              I_EDH_FIELD_CRC_VALID,
    input  wire logic [2:0]        I_LOCAL_ERR_HERE,
    input  wire logic [2:0]        I_LOCAL_INT_HERE,
    input  wire logic              I_RASTER_INPUT_LOCK,
    input  wire logic [3:0]        I_FORMAT_CODE,
    input  wire logic              I_ANC_START,
    input  wire logic              I_ANC_WORD_VALID,
    input  wire logic [9:0]        I_ANC_WORD,
    input  wire logic              I_PID_LINE_OK,
    output logic [15:0]            O_REG_RDATA,
    output logic                   O_REG_RVALID,
    output logic [14:0]            O_EDH_FLAGS_OUT
);

    // Parameter sanity: the map needs offset 10h to be reachable
    generate
        if (ADDR_W < 5) begin : g_bad_addr
            $error("ADDR_W too small for register map");
        end
    endgenerate

    // Pin synchronisers (first stage read only by second stage)
    logic [1:0] lock_sync_r;       // Input lock, two stages
    logic [1:0] bypass_sync_r;     // Bypass pin, two stages
    wire        lock_s   = lock_sync_r[1];
    wire        bypass_s = ~bypass_sync_r[1];  // High while bypassing
    wire        clear_all = ~lock_s | bypass_s;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            lock_sync_r   <= 2'h0;
            bypass_sync_r <= 2'h3;
        end else begin
            lock_sync_r   <= {lock_sync_r[0], I_INPUT_LOCK};
            bypass_sync_r <= {bypass_sync_r[0], I_PROCESSING_BYPASS_N};
        end
    end

    // Host-visible state and its internal helpers
    logic        refresh_en_r;     // Flag refresh enable
    logic [14:0] flags_r;          // Outgoing flags
    logic        present_r;        // Error packet present
    logic        seen_r;           // Packet seen this vblank
    logic        picture_crc_valid_r;       // Picture CRC valid
    logic        field_crc_valid_r;       // Field CRC valid
    logic        vblank_d_r;       // Delayed vblank for edge
    logic        version_r;        // Payload packet version
    logic        raster_lock_r;    // Flywheel lock copy
    logic [3:0]  fmt_code_r;       // Format code copy
    edh_pid_pkg::pid_word_t cap_r [`PID_USER_WORDS];  // Captured words

    // End of vertical blanking
    wire vb_fall = vblank_d_r & ~I_VBLANK;
    // A packet in the same cycle as the edge still counts as seen
    wire seen_now = seen_r | I_EDH_PKT_VALID;

    // Recomputed flags, per area: UNKNOWN_STATUS_FLAG, INTERNAL_ALREADY_FLAG, INTERNAL_HERE_FLAG, EDA, EDH
    logic [14:0] refreshed;
    genvar a;
    generate
        for (a = 0; a < 3; a++) begin : g_area
            assign refreshed[a*5+4] = I_EDH_FLAGS_IN[a*5+4];
            assign refreshed[a*5+3] = I_EDH_FLAGS_IN[a*5+3] |
                                      I_EDH_FLAGS_IN[a*5+2];
            assign refreshed[a*5+2] = I_LOCAL_INT_HERE[a];
            assign refreshed[a*5+1] = I_EDH_FLAGS_IN[a*5+1] |
                                      I_EDH_FLAGS_IN[a*5+0];
            assign refreshed[a*5+0] = I_LOCAL_ERR_HERE[a];
        end
    endgenerate

    // Next packet-present value
    wire present_nxt = I_EDH_PKT_VALID ? 1'b1 :
                       (vb_fall & ~seen_now) ? 1'b0 :
                       present_r;

    // Next flag value: packet load if refresh enabled, else unknown status flags at a vblank end with no packet seen, else hold
    wire [14:0] flags_nxt =
        (I_EDH_PKT_VALID & refresh_en_r) ? refreshed :
        (vb_fall & ~seen_now) ? `UES_MASK :
        flags_r;

    // Detection, flags and CRC valid bits
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            flags_r    <= `RST_EDH_FLAGS;
            present_r  <= 1'b0;
            seen_r     <= 1'b0;
            picture_crc_valid_r <= 1'b0;
            field_crc_valid_r <= 1'b0;
            vblank_d_r <= 1'b0;
        end else begin
            vblank_d_r <= I_VBLANK;
            flags_r    <= flags_nxt;
            present_r  <= present_nxt;
            // Seen marker restarts each vblank, set wins
            seen_r     <= I_EDH_PKT_VALID | (seen_r & ~vb_fall);
            if (!present_nxt) begin
                picture_crc_valid_r <= 1'b0;
                field_crc_valid_r <= 1'b0;
            end else if (I_EDH_PKT_VALID) begin
                picture_crc_valid_r <= I_EDH_PICTURE_CRC_VALID;
                field_crc_valid_r <= I_EDH_FIELD_CRC_VALID;
            end
        end
    end

    // Payload identifier parser
    edh_pid_pkg::pid_state_t state_r;
    logic [8:0]  sum_r;            // Running checksum, low 9 bits
    logic [1:0]  idx_r;            // User word index
    edh_pid_pkg::pid_word_t buf_r [`PID_USER_WORDS];  // Staging words

    wire [8:0] sum_add = sum_r + I_ANC_WORD[8:0];
    // Checksum word: low 9 bits equal sum, bit 9 is inverse of bit 8
    wire csum_ok = (I_ANC_WORD[8:0] == sum_r) &&
                   (I_ANC_WORD[9] == ~sum_r[8]);
    // A new header landing in the checksum slot aborts, never commits
    wire commit = I_ANC_WORD_VALID && !I_ANC_START &&
                  (state_r == edh_pid_pkg::PID_CSUM) &&
                  csum_ok && I_PID_LINE_OK;

    // Sequencing through DID, SDID, DC, user words, checksum
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= edh_pid_pkg::PID_IDLE;
            sum_r   <= 9'h000;
            idx_r   <= 2'h0;
            for (int i = 0; i < `PID_USER_WORDS; i++) begin
                buf_r[i] <= `RST_PAYLOAD_WORD;
            end
        end else if (I_ANC_WORD_VALID) begin
            if (I_ANC_START) begin
                // Restart on any new packet header
                sum_r   <= I_ANC_WORD[8:0];
                idx_r   <= 2'h0;
                state_r <= (I_ANC_WORD[7:0] == PID_DID) ?
                           edh_pid_pkg::PID_SDID : edh_pid_pkg::PID_IDLE;
            end else begin
                sum_r <= sum_add;
                case (state_r)
                    edh_pid_pkg::PID_SDID: begin
                        state_r <= (I_ANC_WORD[7:0] == PID_SDID) ?
                            edh_pid_pkg::PID_COUNT : edh_pid_pkg::PID_IDLE;
                    end
                    edh_pid_pkg::PID_COUNT: begin
                        // Only the four-word form is accepted
                        state_r <= (I_ANC_WORD[7:0] == `PID_DATA_COUNT) ?
                            edh_pid_pkg::PID_USER : edh_pid_pkg::PID_IDLE;
                    end
                    edh_pid_pkg::PID_USER: begin
                        buf_r[idx_r] <= I_ANC_WORD[7:0];
                        idx_r        <= idx_r + 2'h1;
                        if (idx_r == 2'h3) begin
                            state_r <= edh_pid_pkg::PID_CSUM;
                        end
                    end
                    edh_pid_pkg::PID_CSUM: begin
                        state_r <= edh_pid_pkg::PID_IDLE;
                    end
                    default: begin
                        state_r <= edh_pid_pkg::PID_IDLE;
                    end
                endcase
            end
        end
    end

    // Captures, version and raster status; cleared on lock loss
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < `PID_USER_WORDS; i++) begin
                cap_r[i] <= `RST_PAYLOAD_WORD;
            end
            version_r     <= 1'b0;
            raster_lock_r <= 1'b0;
            fmt_code_r    <= `RST_FORMAT_CODE;
        end else if (clear_all) begin
            for (int i = 0; i < `PID_USER_WORDS; i++) begin
                cap_r[i] <= `RST_PAYLOAD_WORD;
            end
            version_r     <= 1'b0;
            raster_lock_r <= 1'b0;
            fmt_code_r    <= `RST_FORMAT_CODE;
        end else begin
            raster_lock_r <= I_RASTER_INPUT_LOCK;
            fmt_code_r    <= I_FORMAT_CODE;
            if (commit) begin
                // Whole packet lands at once, no torn reads
                for (int i = 0; i < `PID_USER_WORDS; i++) begin
                    cap_r[i] <= buf_r[i];
                end
                version_r <= buf_r[0][`PID_VERSION_BIT];
            end
        end
    end

    // Register decode
    wire hit_flags = I_REG_ADDR == ADDR_W'(`OFS_EDH_FLAGS_OUTGOING);
    wire hit_fmt   = I_REG_ADDR == ADDR_W'(`OFS_FORMAT_STATUS);
    wire hit_low   = I_REG_ADDR == ADDR_W'(`OFS_PAYLOAD_ID_LOW);
    wire hit_high  = I_REG_ADDR == ADDR_W'(`OFS_PAYLOAD_ID_HIGH);

    // Format status word, unused bits zero
    logic [15:0] fmt_word;
    always_comb begin
        fmt_word = 16'h0000;
        fmt_word[`BIT_FLAG_REFRESH_ENABLE]  = refresh_en_r;
        fmt_word[`BIT_PICTURE_CRC_VALID]    = picture_crc_valid_r;
        fmt_word[`BIT_FIELD_CRC_VALID]      = field_crc_valid_r;
        fmt_word[`BIT_ERROR_PACKET_PRESENT] = present_r;
        fmt_word[`BIT_PAYLOAD_ID_VERSION]   = version_r;
        fmt_word[`BIT_RASTER_INPUT_LOCK]        = raster_lock_r;
        fmt_word[`FMT_CODE_MSB:0]           = fmt_code_r;
    end

    // Read mux; unmapped addresses read zero
    wire [15:0] rd_mux =
        hit_flags ? {1'b0, flags_r} :
        hit_fmt   ? fmt_word :
        hit_low   ? {cap_r[1], cap_r[0]} :
        hit_high  ? {cap_r[3], cap_r[2]} :
        16'h0000;

    // Host write (only the refresh enable is writable) and read answer
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            refresh_en_r    <= 1'b0;
            O_REG_RDATA     <= 16'h0000;
            O_REG_RVALID    <= 1'b0;
            O_EDH_FLAGS_OUT <= `RST_EDH_FLAGS;
        end else begin
            if (I_REG_WR && hit_fmt) begin
                refresh_en_r <= I_REG_WDATA[`BIT_FLAG_REFRESH_ENABLE];
            end
            O_REG_RVALID    <= I_REG_RD;
            O_REG_RDATA     <= I_REG_RD ? rd_mux : 16'h0000;
            O_EDH_FLAGS_OUT <= flags_nxt;
        end
    end

endmodule

// ### verif/edh_regs_chk.sv
`timescale 1ns/100ps
// Port-level checks on the status and capture register bank
module edh_regs_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic              I_CLOCK,
    input wire logic              I_RST,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic              I_REG_RD,
    input wire logic              I_INPUT_LOCK,
    input wire logic              I_PROCESSING_BYPASS_N,
    input wire logic              I_VBLANK,
    input wire logic              I_EDH_PKT_VALID,
    input wire logic              I_ANC_START,
    input wire logic              I_ANC_WORD_VALID,
    input wire logic [15:0]       O_REG_RDATA,
    input wire logic              O_REG_RVALID,
    input wire logic [14:0]       O_EDH_FLAGS_OUT
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // Capture read: either payload id register
    wire pid_rd = I_REG_RD && (I_REG_ADDR == 8'h0F || I_REG_ADDR == 8'h10);

    rvalid_pulse_a: assert property (I_REG_RD |=> O_REG_RVALID)
        else $error("read strobe without answer");
    rvalid_cause_a: assert property (
        O_REG_RVALID |-> $past(I_REG_RD))
        else $error("answer without read strobe");
    rdata_idle_a: assert property (
        !O_REG_RVALID |-> O_REG_RDATA == 16'h0000)
        else $error("read data not zero while idle");
    flags_read_a: assert property (
        O_REG_RVALID && $past(I_REG_ADDR) == 8'h03
        |-> O_REG_RDATA == {1'b0, $past(O_EDH_FLAGS_OUT)})
        else $error("flag register read differs from flag output");
    fmt_unused_a: assert property (
        O_REG_RVALID && $past(I_REG_ADDR) == 8'h04
        |-> O_REG_RDATA[15:12] == 4'h0 && O_REG_RDATA[6:5] == 2'h0)
        else $error("unused status bits not zero");
    crc_clear_a: assert property (
        O_REG_RVALID && $past(I_REG_ADDR) == 8'h04 && !O_REG_RDATA[8]
        |-> O_REG_RDATA[10:9] == 2'h0)
        else $error("crc valid set without packet present");
    flags_hold_a: assert property (
        $changed(O_EDH_FLAGS_OUT) |-> $past(I_EDH_PKT_VALID) ||
        ($past(I_VBLANK, 2) && !$past(I_VBLANK)))
        else $error("flags changed without packet or blanking end");
    unlock_clear_a: assert property (
        (!I_INPUT_LOCK)[*4] ##0 pid_rd |=> O_REG_RDATA == 16'h0000)
        else $error("capture not cleared on lock loss");
    bypass_clear_a: assert property (
        (!I_PROCESSING_BYPASS_N)[*4] ##0 pid_rd |=> O_REG_RDATA == 16'h0000)
        else $error("capture not cleared on bypass");
    // Main scenarios reached
    cover property (I_EDH_PKT_VALID && I_VBLANK);
    cover property ($fell(I_VBLANK));
    cover property (I_ANC_START ##7 I_ANC_WORD_VALID);
endmodule
bind edh_status_payload_id_regs edh_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### verif/anc_source_model.sv
`timescale 1ns/100ps
// Upstream video source: emits payload identifier ancillary packets
module anc_source_model (
    input  wire logic i_clock,
    output logic       o_start,
    output logic       o_valid,
    output logic [9:0] o_word,
    output logic       o_line_ok
);
    initial begin
        o_start = 1'b0;
        o_valid = 1'b0;
        o_word = 10'h155;
        o_line_ok = 1'b0;
    end
    // Word with its two parity bits on top
    function automatic logic [9:0] pw(input logic [7:0] b);
        return {~^b, ^b, b};
    endfunction
    // Send one packet; bad spoils the checksum, line places it on a line
    task automatic send(input logic [31:0] w, input logic bad,
                        input logic line);
        logic [9:0] pk[8];
        logic [8:0] s;
        pk[0] = pw(8'h41);
        pk[1] = pw(8'h01);
        pk[2] = pw(8'h04);
        for (int i = 0; i < 4; i++) pk[3+i] = pw(w[8*i+:8]);
        s = 9'h000;
        for (int i = 0; i < 7; i++) s = s + pk[i][8:0];
        if (bad) s = s ^ 9'h001;
        pk[7] = {~s[8], s};
        for (int i = 0; i < 8; i++) begin
            @(negedge i_clock);
            o_start <= (i == 0);
            o_valid <= 1'b1;
            o_word <= pk[i];
            o_line_ok <= line;
        end
        @(negedge i_clock);
        o_start <= 1'b0;
        o_valid <= 1'b0;
        // Released bus shows the inverse, not a stale word
        o_word <= ~pk[7];
        o_line_ok <= 1'b0;
    endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, lock = 1, byp_n = 1;
    logic        vb = 0, pv = 0, apv = 0, ffv = 0, rl = 0, st, av, lok, rv;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wd = 16'h0000, rdata;
    logic [14:0] fin = 15'h0000, fout, flg = 15'h0000;
    logic [2:0]  le = 3'h0, li = 3'h0;
    logic [3:0]  fmt = 4'h0;
    logic [9:0]  aw;
    logic [31:0] seed = 32'h963AB7AF, pid;
    int          bad_count = 0, check_count = 0;
    logic [7:0]  tbl[5] = '{8'h03, 8'h04, 8'h0F, 8'h10, 8'h07};

    edh_status_payload_id_regs u_dut (.I_CLOCK(clk), .I_RST(rst),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd),
        .I_INPUT_LOCK(lock), .I_PROCESSING_BYPASS_N(byp_n), .I_VBLANK(vb),
        .I_EDH_PKT_VALID(pv), .I_EDH_FLAGS_IN(fin), .I_EDH_PICTURE_CRC_VALID(apv),
        .I_EDH_FIELD_CRC_VALID(ffv), .I_LOCAL_ERR_HERE(le), .I_LOCAL_INT_HERE(li),
        .I_RASTER_INPUT_LOCK(rl), .I_FORMAT_CODE(fmt), .I_ANC_START(st),
        .I_ANC_WORD_VALID(av), .I_ANC_WORD(aw), .I_PID_LINE_OK(lok),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rv), .O_EDH_FLAGS_OUT(fout));
    anc_source_model u_src (.i_clock(clk), .o_start(st), .o_valid(av),
        .o_word(aw), .o_line_ok(lok));

    initial forever #5 clk = ~clk;
    // Hang guard: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    // Expected refreshed flags: already flags fold in the here flags
    function automatic logic [14:0] refresh(input logic [14:0] f,
                                            input logic [2:0] e, n);
        for (int a = 0; a < 3; a++) refresh[5*a+:5] = {f[5*a+4],
            f[5*a+3] | f[5*a+2], n[a], f[5*a+1] | f[5*a], e[a]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Read strobe, answer one cycle later
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp,
                       input string nm);
        @(negedge clk);
        rd = 1;
        addr = a;
        @(negedge clk);
        rd = 0;
        chk("read valid", 16'h0001, {15'h0000, rv});
        chk(nm, exp, rdata);
    endtask
    task automatic wrc(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 0;
        wd = ~d;
    endtask
    // One blanking interval, optionally with an error packet inside
    task automatic blank(input logic pkt, input logic en);
        @(negedge clk);
        vb = 1;
        if (pkt) begin
            seed = lfsr(seed);
            {fin, le, li, apv, ffv} = seed[22:0];
            pv = 1;
            if (en) flg = refresh(fin, le, li);
            @(negedge clk);
            pv = 0;
            fin = ~fin; // Only valid with the pulse
        end
        repeat (2) @(negedge clk);
        vb = 0;
        repeat (3) @(negedge clk);
    endtask
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 5; i++) rdc(tbl[i], 16'h0000, "reset");
        seed = lfsr(seed);
        fmt = seed[3:0];
        rl = 1;
        wrc(8'h03, 16'hFFFF);
        wrc(8'h04, 16'hFFFF);
        rdc(8'h04, {4'h0, 1'b1, 6'h00, 1'b1, fmt}, "status");
        rdc(8'h03, 16'h0000, "flags");
        for (int i = 0; i < 3; i++) begin
            blank(1, 1);
            rdc(8'h03, {1'b0, flg}, "flags");
            chk("flag out", {1'b0, flg}, {1'b0, fout});
            rdc(8'h04, {4'h0, 1'b1, apv, ffv, 2'h2, 2'h0, 1'b1, fmt},
                "status");
        end
        wrc(8'h04, 16'hF7FF);
        blank(1, 0);
        rdc(8'h03, {1'b0, flg}, "held flags");
        blank(0, 0);
        rdc(8'h03, 16'h4210, "unknown flags");
        rdc(8'h04, {12'h001, fmt}, "status");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            pid = {seed[31:8], i[0], seed[6:0]};
            u_src.send(pid, 0, 1);
            rdc(8'h0F, pid[15:0], "words 1 2");
            rdc(8'h10, pid[31:16], "words 3 4");
            rdc(8'h04, {8'h00, i[0], 2'h0, 1'b1, fmt}, "version");
        end
        seed = lfsr(seed);
        u_src.send(seed, 1, 1);
        rdc(8'h0F, pid[15:0], "bad sum");
        u_src.send(seed, 0, 0);
        rdc(8'h10, pid[31:16], "wrong line");
        lock = 0;
        repeat (4) @(negedge clk);
        rdc(8'h0F, 16'h0000, "lock loss");
        lock = 1;
        repeat (3) @(negedge clk);
        u_src.send(pid, 0, 1);
        byp_n = 0;
        repeat (4) @(negedge clk);
        rdc(8'h10, 16'h0000, "bypass");
        byp_n = 1;
        finish_test();
    end
endmodule
